// ---- shared/tcu_pkg.sv ----
package tcu_pkg;
    // register byte offsets on the APB bus
    localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
    localparam logic [7:0] ADDR_COUNT     = 8'h08;
    localparam logic [7:0] ADDR_CMP_A     = 8'h0C;
    localparam logic [7:0] ADDR_CMP_B     = 8'h10;
    localparam logic [7:0] ADDR_MASK      = 8'h14;
    localparam logic [7:0] ADDR_FLAG      = 8'h18;
    localparam logic [7:0] ADDR_PRESCALE  = 8'h1C;

    // control register a fields
    localparam int CA_WGM0   = 0;
    localparam int CA_WGM1   = 1;
    localparam int CA_COMB_L = 4;
    localparam int CA_COMA_L = 6;
    // control register b fields
    localparam int CB_CS_L   = 0;
    localparam int CB_WGM2   = 3;
    localparam int CB_FOCB   = 6;
    localparam int CB_FOCA   = 7;
    // flag and mask bit positions
    localparam int FL_OVF    = 1;
    localparam int FL_CMPA   = 4;
    localparam int FL_CMPB   = 3;

    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // clock select codes
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIVP    = 3'h2;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // waveform modes
    typedef enum logic [2:0] {
        WM_NORMAL    = 3'b000,
        WM_PHASE_MAX = 3'b001,
        WM_CLR_MATCH = 3'b010,
        WM_FAST_MAX  = 3'b011,
        WM_RSV4      = 3'b100,
        WM_PHASE_A   = 3'b101,
        WM_RSV6      = 3'b110,
        WM_FAST_A    = 3'b111
    } tcu_mode_t;

    // compare output mode actions
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;
endpackage : tcu_pkg

// ---- src/tcu_timer.sv ----
// Contract
// - count and both compare values are 8 bits; comparator works on 8 bits
// - tick from prescaled clock or chosen edge of external pin; select zero stops
// - bottom when count is 0x00, max when count is 0xFF
// - top is 0xFF or compare value a, by mode
// - each tick clears, increments or decrements by mode; both directions
// - software may read and write the count at any time
// - software count write beats clear or count on the same cycle
// - 3-bit mode field: two bits in control a, top bit in control b
// - overflow flag set at mode-dependent points; can raise an interrupt
// - separate match signal whenever count equals compare a or b
// - compare flag set on the tick after a match; request when enabled
// - compare flag cleared on service or by writing one
// - all requests in one flag register, each masked individually
// - compare values double-buffered in pwm modes only
// - buffered value moves to active compare at top, in every pwm mode
// - with buffering, software reaches the buffer; otherwise the active register
// - force bit in non-pwm modes acts on output only, no flag, no clear
// - count write blocks every match in the next tick, even when stopped
// - compare output state kept across mode changes
// - compare output mode changes act at once, not buffered
// - compare output state cleared to zero on reset
// - mode zero is normal: count up, no clear, wrap 0xFF to 0x00
`timescale 1ns/100ps
module tcu_timer (
    input  wire logic        pclk,          // bus clock, 250 MHz
    input  wire logic        presetn,       // async reset, active low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error, unmapped address
    input  wire logic        ext_count_pin, // external count pin, async
    input  wire logic        irq_ack_ovf,   // service strobe, overflow
    input  wire logic        irq_ack_cmpa,  // service strobe, compare a
    input  wire logic        irq_ack_cmpb,  // service strobe, compare b
    output logic             compare_output_a, // compare output a state
    output logic             compare_output_b, // compare output b state
    output logic             irq_ovf,       // overflow request
    output logic             irq_cmpa,      // compare a request
    output logic             irq_cmpb       // compare b request
);
    typedef struct packed {
        logic [7:0]  control_register_a;
        logic [7:0]  control_register_b;
        logic [7:0]  count_value;
        logic [7:0]  compare_value_a;
        logic [7:0]  compare_value_b;
        logic [7:0]  buffer_a;
        logic [7:0]  buffer_b;
        logic [7:0]  timer_mask_register;
        logic [7:0]  timer_flag_register;
        logic [7:0]  prescale_div;
        logic [7:0]  prescale_cnt;
        logic        direction_down;
        logic        block_match;
        logic [2:0]  pin_sync;
        logic        out_a;
        logic        out_b;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        irq_o;
        logic        irq_a;
        logic        irq_b;
    } tcu_state_t;

    tcu_state_t st;
    tcu_state_t next_st;

    // action of a compare output mode on a match, non-pwm style
    function automatic logic tcu_apply(input logic [1:0] com, input logic cur);
        case (com)
            tcu_pkg::COM_TOGGLE: tcu_apply = ~cur;
            tcu_pkg::COM_CLEAR:  tcu_apply = 1'b0;
            tcu_pkg::COM_SET:    tcu_apply = 1'b1;
            default:             tcu_apply = cur;
        endcase
    endfunction : tcu_apply

    // pwm output on a match or at bottom; inverting when both bits set
    function automatic logic tcu_pwm(input logic [1:0] com, input logic cur, input logic at_bottom,
                                     input logic up);
        if (com == tcu_pkg::COM_CLEAR)
            tcu_pwm = at_bottom ? 1'b1 : ~up;
        else if (com == tcu_pkg::COM_SET)
            tcu_pwm = at_bottom ? 1'b0 : up;
        else
            tcu_pwm = cur;
    endfunction : tcu_pwm

    logic        wr_en;
    logic        rd_en;
    logic [7:0]  wbyte;
    tcu_pkg::tcu_mode_t mode;
    logic        pwm_mode;
    logic        phase_mode;
    logic [7:0]  top_val;
    logic        tick;
    logic        ext_rise;
    logic        ext_fall;
    logic        is_bottom;
    logic        is_max;
    logic        is_top;
    logic        match_a;
    logic        match_b;
    logic        eff_a;
    logic        eff_b;
    logic [2:0]  cs;
    logic [1:0]  com_a;
    logic [1:0]  com_b;
    logic [7:0]  flags_set;
    logic [7:0]  flags_clr;
    logic [7:0]  req_bits;

    always_comb begin
        next_st   = st;
        wr_en     = psel && penable && pwrite;
        rd_en     = psel && !penable && !pwrite;
        wbyte     = pwdata[7:0];
        // mode field split over both control registers
        mode      = tcu_pkg::tcu_mode_t'({st.control_register_b[tcu_pkg::CB_WGM2],
                                         st.control_register_a[tcu_pkg::CA_WGM1],
                                         st.control_register_a[tcu_pkg::CA_WGM0]});
        pwm_mode  = st.control_register_a[tcu_pkg::CA_WGM0];
        phase_mode = pwm_mode && !st.control_register_a[tcu_pkg::CA_WGM1];
        top_val   = (mode == tcu_pkg::WM_CLR_MATCH || mode == tcu_pkg::WM_PHASE_A ||
                     mode == tcu_pkg::WM_FAST_A) ? st.compare_value_a : tcu_pkg::CNT_MAX;
        cs        = st.control_register_b[tcu_pkg::CB_CS_L +: 3];
        com_a     = st.control_register_a[tcu_pkg::CA_COMA_L +: 2];
        com_b     = st.control_register_a[tcu_pkg::CA_COMB_L +: 2];
        // edge detect reads only the second and third stages
        ext_rise  = st.pin_sync[1] && !st.pin_sync[2];
        ext_fall  = !st.pin_sync[1] && st.pin_sync[2];
        case (cs)
            tcu_pkg::CS_STOP:     tick = 1'b0;
            tcu_pkg::CS_DIV1:     tick = 1'b1;
            tcu_pkg::CS_EXT_FALL: tick = ext_fall;
            tcu_pkg::CS_EXT_RISE: tick = ext_rise;
            default:              tick = (st.prescale_cnt == tcu_pkg::RST_BYTE);
        endcase
        // prescaler runs from the divide register at all times, whatever clock is picked
        if (st.prescale_cnt >= st.prescale_div)
            next_st.prescale_cnt = tcu_pkg::RST_BYTE;
        else
            next_st.prescale_cnt = st.prescale_cnt + 8'h01;
        next_st.pin_sync = {st.pin_sync[1:0], ext_count_pin};

        is_bottom = (st.count_value == tcu_pkg::CNT_BOTTOM);
        is_max    = (st.count_value == tcu_pkg::CNT_MAX);
        is_top    = (st.count_value == top_val);
        match_a   = (st.count_value == st.compare_value_a);
        match_b   = (st.count_value == st.compare_value_b);
        eff_a     = match_a && !st.block_match;
        eff_b     = match_b && !st.block_match;

        flags_set = 8'h00;
        flags_clr = 8'h00;
        if (tick) begin
            // a tick consumes the blocking window
            next_st.block_match = 1'b0;
            if (eff_a) flags_set[tcu_pkg::FL_CMPA] = 1'b1;
            if (eff_b) flags_set[tcu_pkg::FL_CMPB] = 1'b1;
            // count sequence per mode
            if (phase_mode) begin
                if (is_top && !st.direction_down) begin
                    next_st.direction_down = 1'b1;
                    next_st.count_value = st.count_value - 8'h01;
                end else if (is_bottom && st.direction_down) begin
                    next_st.direction_down = 1'b0;
                    next_st.count_value = st.count_value + 8'h01;
                    flags_set[tcu_pkg::FL_OVF] = 1'b1;
                end else if (st.direction_down) begin
                    next_st.count_value = st.count_value - 8'h01;
                end else begin
                    next_st.count_value = st.count_value + 8'h01;
                end
            end else begin
                next_st.direction_down = 1'b0;
                if (mode != tcu_pkg::WM_NORMAL && is_top) begin
                    next_st.count_value = tcu_pkg::CNT_BOTTOM;
                    if (pwm_mode) flags_set[tcu_pkg::FL_OVF] = 1'b1;
                end else begin
                    next_st.count_value = st.count_value + 8'h01;
                end
                if (is_max && !(pwm_mode && is_top)) flags_set[tcu_pkg::FL_OVF] = 1'b1;
            end
            // buffered compare update at top, in every pwm mode
            if (pwm_mode && ((phase_mode && is_top) || (!phase_mode && is_top))) begin
                next_st.compare_value_a = st.buffer_a;
                next_st.compare_value_b = st.buffer_b;
            end
            // output compare state; untouched on mode switches
            if (pwm_mode) begin
                if (eff_a) next_st.out_a = tcu_pwm(com_a, st.out_a, 1'b0, !st.direction_down);
                if (eff_b) next_st.out_b = tcu_pwm(com_b, st.out_b, 1'b0, !st.direction_down);
                if (!phase_mode && is_top) begin
                    next_st.out_a = tcu_pwm(com_a, st.out_a, 1'b1, 1'b1);
                    next_st.out_b = tcu_pwm(com_b, st.out_b, 1'b1, 1'b1);
                end
            end else begin
                if (eff_a) next_st.out_a = tcu_apply(com_a, st.out_a);
                if (eff_b) next_st.out_b = tcu_apply(com_b, st.out_b);
            end
        end

        // service strobes clear flags
        if (irq_ack_ovf)  flags_clr[tcu_pkg::FL_OVF]  = 1'b1;
        if (irq_ack_cmpa) flags_clr[tcu_pkg::FL_CMPA] = 1'b1;
        if (irq_ack_cmpb) flags_clr[tcu_pkg::FL_CMPB] = 1'b1;

        // register writes take effect at the access edge
        if (wr_en) begin
            case (paddr)
                tcu_pkg::ADDR_CTRL_A: next_st.control_register_a = wbyte;
                tcu_pkg::ADDR_CTRL_B: begin
                    // force bits are strobes and read back as zero
                    next_st.control_register_b = {2'b00, wbyte[5:0]};
                    if (!pwm_mode && wbyte[tcu_pkg::CB_FOCA])
                        next_st.out_a = tcu_apply(com_a, st.out_a);
                    if (!pwm_mode && wbyte[tcu_pkg::CB_FOCB])
                        next_st.out_b = tcu_apply(com_b, st.out_b);
                end
                tcu_pkg::ADDR_COUNT: begin
                    next_st.count_value = wbyte;
                    next_st.block_match = 1'b1;
                end
                tcu_pkg::ADDR_CMP_A: begin
                    if (pwm_mode) next_st.buffer_a = wbyte;
                    else          next_st.compare_value_a = wbyte;
                end
                tcu_pkg::ADDR_CMP_B: begin
                    if (pwm_mode) next_st.buffer_b = wbyte;
                    else          next_st.compare_value_b = wbyte;
                end
                tcu_pkg::ADDR_MASK:     next_st.timer_mask_register = wbyte;
                tcu_pkg::ADDR_FLAG:     flags_clr = flags_clr | wbyte;
                tcu_pkg::ADDR_PRESCALE: next_st.prescale_div = wbyte;
                default: ;
            endcase
        end
        // set wins over clear
        next_st.timer_flag_register = (st.timer_flag_register & ~flags_clr) | flags_set;
        // requests built from the next flag and mask, so the flop shows them with the flags
        req_bits      = next_st.timer_flag_register & next_st.timer_mask_register;
        next_st.irq_o = req_bits[tcu_pkg::FL_OVF];
        next_st.irq_a = req_bits[tcu_pkg::FL_CMPA];
        next_st.irq_b = req_bits[tcu_pkg::FL_CMPB];

        // reads sampled in setup so data stands in the access phase
        if (rd_en) begin
            case (paddr)
                tcu_pkg::ADDR_CTRL_A:   next_st.rdata = {24'h000000, st.control_register_a};
                tcu_pkg::ADDR_CTRL_B:   next_st.rdata = {24'h000000, st.control_register_b};
                tcu_pkg::ADDR_COUNT:    next_st.rdata = {24'h000000, st.count_value};
                tcu_pkg::ADDR_CMP_A:    next_st.rdata = {24'h000000,
                                                         pwm_mode ? st.buffer_a : st.compare_value_a};
                tcu_pkg::ADDR_CMP_B:    next_st.rdata = {24'h000000,
                                                         pwm_mode ? st.buffer_b : st.compare_value_b};
                tcu_pkg::ADDR_MASK:     next_st.rdata = {24'h000000, st.timer_mask_register};
                tcu_pkg::ADDR_FLAG:     next_st.rdata = {24'h000000, st.timer_flag_register};
                tcu_pkg::ADDR_PRESCALE: next_st.rdata = {24'h000000, st.prescale_div};
                default:                next_st.rdata = 32'h00000000;
            endcase
        end
        // no wait state: ready and error in the cycle after setup
        next_st.ready  = psel && !penable;
        next_st.slverr = psel && !penable && (paddr > tcu_pkg::ADDR_PRESCALE || paddr[1:0] != 2'b00);
        // a write uses the access edge; gate its effect on ready
        if (wr_en && !st.ready) begin
            next_st = st;
            next_st.pin_sync = {st.pin_sync[1:0], ext_count_pin};
            next_st.ready  = 1'b1;
            next_st.slverr = st.slverr;
        end
    end

    // single state register; only constants under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign prdata           = st.rdata;
    assign pready           = st.ready;
    assign pslverr          = st.slverr;
    assign compare_output_a = st.out_a;
    assign compare_output_b = st.out_b;
    // requests registered like every other output
    assign irq_ovf  = st.irq_o;
    assign irq_cmpa = st.irq_a;
    assign irq_cmpb = st.irq_b;
endmodule : tcu_timer

// ---- tb/tcu_timer_asserts.sv ----
`timescale 1ns/100ps
module tcu_timer_asserts (
    input wire logic        pclk,             // bus clock
    input wire logic        presetn,          // async reset, active low
    input wire logic        psel,             // apb select
    input wire logic        penable,          // apb access phase
    input wire logic        pwrite,           // apb direction
    input wire logic [7:0]  paddr,            // apb byte address
    input wire logic [31:0] pwdata,           // apb write data
    input wire logic [31:0] prdata,           // apb read data
    input wire logic        pready,           // apb ready
    input wire logic        pslverr,          // apb error
    input wire logic        ext_count_pin,    // external count pin
    input wire logic        irq_ack_ovf,      // service strobe, overflow
    input wire logic        irq_ack_cmpa,     // service strobe, compare a
    input wire logic        irq_ack_cmpb,     // service strobe, compare b
    input wire logic        compare_output_a, // compare output a state
    input wire logic        compare_output_b, // compare output b state
    input wire logic        irq_ovf,          // overflow request
    input wire logic        irq_cmpa,         // compare a request
    input wire logic        irq_cmpb          // compare b request
);
    // one domain, so clock and reset are stated once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_err_unmapped;
        psel && !penable && (paddr > 8'h1C || paddr[1:0] != 2'h0) |=> pslverr && pready;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    property p_ok_mapped;
        psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
    property p_upper_zero; pready |-> prdata[31:8] == 24'h000000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data wider than a byte");
    property p_err_read_zero; pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
    a_err_read_zero: assert property (p_err_read_zero) else $error("refused read not zero");
    // first edge after release still sees the cleared state
    property p_reset_out;
        $rose(presetn) |-> !compare_output_a && !compare_output_b && !irq_ovf && !irq_cmpa && !irq_cmpb;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
endmodule : tcu_timer_asserts

bind tcu_timer tcu_timer_asserts tcu_chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(ext_count_pin), .irq_ack_ovf(irq_ack_ovf), .irq_ack_cmpa(irq_ack_cmpa),
    .irq_ack_cmpb(irq_ack_cmpb), .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
    .irq_ovf(irq_ovf), .irq_cmpa(irq_cmpa), .irq_cmpb(irq_cmpb));

// ---- tb/timer_counter_compare_unit_test.sv ----
`timescale 1ns/100ps
module timer_counter_compare_unit_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rdv;
    logic        pready, pslverr, ext_pin = 1'b0, ack_o = 1'b0, ack_a = 1'b0, ack_b = 1'b0;
    logic        out_a, out_b, irq_o, irq_a, irq_b, erv, oa;
    logic [31:0] mdl [8];
    int          err_count = 0, samples_checked = 0, n;
    logic [1:0]  codes [4] = '{2'h3, 2'h2, 2'h1, 2'h0};

    always #2 pclk = ~pclk;

    tcu_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_pin(ext_pin), .irq_ack_ovf(ack_o), .irq_ack_cmpa(ack_a), .irq_ack_cmpb(ack_b),
        .compare_output_a(out_a), .compare_output_b(out_b), .irq_ovf(irq_o), .irq_cmpa(irq_a),
        .irq_cmpb(irq_b));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // register image: low byte only, force bits read back as zero
        if (w && a <= 8'h1C && a[1:0] == 2'h0 && a != tcu_pkg::ADDR_FLAG)
            mdl[a[4:2]] = d & ((a == tcu_pkg::ADDR_CTRL_B) ? 32'h3F : 32'hFF);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, erv);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rdv, erv);
        chk(rdv, e);
    endtask : rd_chk

    // run the timer on the bus clock for a while, then stop it
    task automatic run(input int cyc);
        wr(tcu_pkg::ADDR_CTRL_B, {29'h0, tcu_pkg::CS_DIV1});
        repeat (cyc) @(posedge pclk);
        wr(tcu_pkg::ADDR_CTRL_B, 32'h0);
    endtask : run

    task automatic wrap_up;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #(4 * 20000);
        err_count++;
        wrap_up;
    end

    initial begin
        for (int i = 0; i < 8; i++) mdl[i] = {24'h0, tcu_pkg::RST_BYTE};
        void'($urandom(18403));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk({out_a, out_b}, 32'h0);
        for (int i = 0; i < 8; i++) rd_chk(8'(i * 4), mdl[i]);
        // random values through the count, compare, mask and prescale registers while stopped
        for (int i = 2; i < 8; i++) begin
            if (i == 6) continue;
            wr(8'(i * 4), $urandom);
            repeat (20) @(posedge pclk);
            rd_chk(8'(i * 4), mdl[i]);
        end
        apb(1'b0, 8'h20, 32'h0, rdv, erv);
        chk({erv, rdv[30:0]}, 32'h80000000);
        apb(1'b1, 8'h09, 32'hFF, rdv, erv);
        chk({31'h0, erv}, 32'h1);
        // forced compare under every output action, both units
        wr(tcu_pkg::ADDR_CMP_A, 32'h80);
        wr(tcu_pkg::ADDR_CMP_B, 32'h80);
        wr(tcu_pkg::ADDR_FLAG, 32'h1A);
        oa = 1'b0;
        foreach (codes[i]) begin
            wr(tcu_pkg::ADDR_CTRL_A, {24'h0, codes[i], codes[i], 4'h0});
            wr(tcu_pkg::ADDR_CTRL_B, 32'hC0);
            repeat (2) @(posedge pclk);
            oa = (codes[i] == 2'h1) ? !oa : (codes[i] == 2'h2) ? 1'b0 : (codes[i] == 2'h3) ? 1'b1 : oa;
            chk({out_a, out_b}, {30'h0, oa, oa});
        end
        rd_chk(tcu_pkg::ADDR_CTRL_B, mdl[1]);
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h0);
        wr(tcu_pkg::ADDR_CTRL_A, 32'h03);
        repeat (2) @(posedge pclk);
        chk({out_a, out_b}, {30'h0, oa, oa});
        wr(tcu_pkg::ADDR_CTRL_A, 32'h00);
        // five rising edges on the external pin
        wr(tcu_pkg::ADDR_COUNT, 32'h0);
        wr(tcu_pkg::ADDR_CTRL_B, {29'h0, tcu_pkg::CS_EXT_RISE});
        repeat (5) begin
            repeat (4) @(posedge pclk);
            ext_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_pin <= 1'b0;
        end
        repeat (6) @(posedge pclk);
        wr(tcu_pkg::ADDR_CTRL_B, 32'h0);
        rd_chk(tcu_pkg::ADDR_COUNT, 32'h05);
        // overflow in normal mode; compare a flagged but masked off
        wr(tcu_pkg::ADDR_FLAG, 32'h1A);
        wr(tcu_pkg::ADDR_MASK, 32'h02);
        wr(tcu_pkg::ADDR_CMP_A, 32'hFC);
        wr(tcu_pkg::ADDR_COUNT, 32'hFA);
        wr(tcu_pkg::ADDR_CTRL_B, {29'h0, tcu_pkg::CS_DIV1});
        for (n = 0; n < 300 && irq_o !== 1'b1; n++) @(posedge pclk);
        wr(tcu_pkg::ADDR_CTRL_B, 32'h0);
        chk({irq_o, irq_a}, 32'h2);
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h12);
        @(posedge pclk) ack_o <= 1'b1;
        @(posedge pclk) ack_o <= 1'b0;
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h10);
        chk({31'h0, irq_o}, 32'h0);
        // compare matches on both units, then the two ways of clearing
        wr(tcu_pkg::ADDR_FLAG, 32'h1A);
        wr(tcu_pkg::ADDR_MASK, 32'h18);
        wr(tcu_pkg::ADDR_CMP_A, 32'h10);
        wr(tcu_pkg::ADDR_CMP_B, 32'h08);
        wr(tcu_pkg::ADDR_COUNT, 32'h00);
        wr(tcu_pkg::ADDR_CTRL_B, {29'h0, tcu_pkg::CS_DIV1});
        for (n = 0; n < 300 && irq_a !== 1'b1; n++) @(posedge pclk);
        wr(tcu_pkg::ADDR_CTRL_B, 32'h0);
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h18);
        wr(tcu_pkg::ADDR_FLAG, 32'h10);
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h08);
        chk({irq_a, irq_b}, 32'h1);
        @(posedge pclk) ack_b <= 1'b1;
        @(posedge pclk) ack_b <= 1'b0;
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h00);
        // clear on match with compare a as the top
        wr(tcu_pkg::ADDR_CTRL_A, 32'h02);
        wr(tcu_pkg::ADDR_CMP_A, 32'h05);
        wr(tcu_pkg::ADDR_CMP_B, 32'h80);
        wr(tcu_pkg::ADDR_COUNT, 32'h00);
        run(40);
        apb(1'b0, tcu_pkg::ADDR_COUNT, 32'h0, rdv, erv);
        chk({31'h0, rdv <= 32'h05}, 32'h1);
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h10);
        // count written equal to compare a: that match is swallowed
        wr(tcu_pkg::ADDR_CTRL_A, 32'h00);
        wr(tcu_pkg::ADDR_FLAG, 32'h1A);
        wr(tcu_pkg::ADDR_CMP_A, 32'h33);
        wr(tcu_pkg::ADDR_COUNT, 32'h33);
        run(20);
        rd_chk(tcu_pkg::ADDR_FLAG, 32'h00);
        // fast pwm: software reaches the buffer, the active value moves at top
        wr(tcu_pkg::ADDR_CTRL_A, 32'h03);
        wr(tcu_pkg::ADDR_CMP_A, 32'h66);
        rd_chk(tcu_pkg::ADDR_CMP_A, 32'h66);
        wr(tcu_pkg::ADDR_CTRL_A, 32'h00);
        rd_chk(tcu_pkg::ADDR_CMP_A, 32'h33);
        wr(tcu_pkg::ADDR_CTRL_A, 32'h03);
        wr(tcu_pkg::ADDR_COUNT, 32'hF0);
        run(40);
        wr(tcu_pkg::ADDR_CTRL_A, 32'h00);
        rd_chk(tcu_pkg::ADDR_CMP_A, 32'h66);
        // prescaled clock, divide by four over 43 timer edges
        wr(tcu_pkg::ADDR_PRESCALE, 32'h03);
        wr(tcu_pkg::ADDR_COUNT, 32'h00);
        wr(tcu_pkg::ADDR_CTRL_B, {29'h0, tcu_pkg::CS_DIVP});
        repeat (40) @(posedge pclk);
        wr(tcu_pkg::ADDR_CTRL_B, 32'h0);
        apb(1'b0, tcu_pkg::ADDR_COUNT, 32'h0, rdv, erv);
        chk({31'h0, rdv >= 32'h0A && rdv <= 32'h0B}, 32'h1);
        wrap_up;
    end
endmodule : timer_counter_compare_unit_test
